// ### dipc_pkg.sv
/*
  shared constants and carrier types for the dual input position capture readout.
  assumes a single drive clock and a simple parameter access port (no public bus).
*/
`default_nettype none
package dipc_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int POS_W  = 32;   // captured position, signed
  localparam int CNT_W  = 16;   // event counters, unsigned
  localparam int ADDR_W = 16;   // parameter address width
  localparam int DATA_W = 32;   // read data width
  localparam int NIB_W  = 4;    // counter slice in the summary word
  localparam int N_IN   = 2;    // capture inputs
  localparam int SYNC_W = 3;    // pin synchroniser depth
  // ----------------------------------------------------------------
  // parameter addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADR_IN1_RISE_POS = 16'h0a4a;
  localparam logic [ADDR_W-1:0] ADR_IN1_FALL_POS = 16'h0a4c;
  localparam logic [ADDR_W-1:0] ADR_IN2_RISE_POS = 16'h0a4e;
  localparam logic [ADDR_W-1:0] ADR_IN2_FALL_POS = 16'h0a50;
  localparam logic [ADDR_W-1:0] ADR_IN1_RISE_CNT = 16'h0a56;
  localparam logic [ADDR_W-1:0] ADR_IN1_FALL_CNT = 16'h0a58;
  localparam logic [ADDR_W-1:0] ADR_IN2_RISE_CNT = 16'h0a5a;
  localparam logic [ADDR_W-1:0] ADR_IN2_FALL_CNT = 16'h0a5c;
  localparam logic [ADDR_W-1:0] ADR_SUMMARY      = 16'h0a5e;
  localparam logic [ADDR_W-1:0] ADR_CONTROL      = 16'h1b74;
  localparam logic [ADDR_W-1:0] ADR_STATUS       = 16'h1b76;
  // ----------------------------------------------------------------
  // control / status field positions, per input byte
  // ----------------------------------------------------------------
  localparam int IN_STRIDE = 8;  // input 2 fields sit one byte up
  localparam int CTL_ACT   = 0;  // input activate
  localparam int CTL_CONT  = 1;  // continuous (1) or one-time (0)
  localparam int CTL_RISE  = 4;  // rising edge capture enable
  localparam int CTL_FALL  = 5;  // falling edge capture enable
  localparam int ST_ACT    = 0;  // input activated
  localparam int ST_RISE   = 1;  // rising value captured
  localparam int ST_FALL   = 2;  // falling value captured
  localparam logic [15:0] CTL_MASK  = 16'h3333; // reserved bits read zero
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam int EDGE_RISE = 0;  // index of rising edge slot
  localparam int EDGE_FALL = 1;  // index of falling edge slot
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              wr;     // write strobe, one cycle
    logic              rd;     // read strobe, one cycle
    logic [ADDR_W-1:0] addr;   // parameter address
    logic [15:0]       wdata;  // write data
  } dipc_req_type;

  typedef struct packed {
    logic              shift;  // origin redefined, one cycle
    logic [POS_W-1:0]  delta;  // amount added to stored positions
  } dipc_origin_type;
endpackage : dipc_pkg
`default_nettype wire

// ### dipc_capture.sv
/*
  dual input position capture readout: pin synchronisers, edge capture of the
  motor position, event counters, control/status words and the parameter port.
  the port answers each read one cycle later; only the control word is writable.
  assumes motor position comes from logic on clk_in and capture pins are async.
*/
// How it works
// - input 1 rising edge stores position
// - input 1 falling edge stores position
// - input 2 rising edge stores position
// - input 2 falling edge stores position
// - origin change shifts every stored position
// - count input 1 rising captures
// - count input 1 falling captures
// - count input 2 rising captures
// - count input 2 falling captures
// - activating input 1 clears its counters
// - activating input 2 clears its counters
// - summary bits 0-7 hold input 1 nibbles
// - summary bits 8-15 hold input 2 nibbles
// - control bits 0 and 8 activate inputs
// - one-time captures first edge, continuous overwrites
// - control bits 4/12 rise, 5/13 fall enable
// - status bits 1,2,9,10 flag captured values
`timescale 1ns/1ps
`default_nettype none
module dipc_capture (
  input  wire logic                          clk_in,
  input  wire logic                          rst_in,
  input  wire logic [dipc_pkg::N_IN-1:0]     cap_pin_in,   // async capture pins
  input  wire logic [dipc_pkg::POS_W-1:0]    motor_pos_in, // current position
  input  wire dipc_pkg::dipc_origin_type     origin_in,    // origin redefinition
  input  wire dipc_pkg::dipc_req_type        req_in,       // parameter access
  output logic      [dipc_pkg::DATA_W-1:0]   rd_data_out,  // read answer
  output logic                               rd_valid_out  // answer strobe
);
  import dipc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // per input and per edge state is indexed [input][edge]
  logic [SYNC_W-1:0] sync_r [N_IN];          // pin synchroniser chains
  logic [N_IN-1:0]   lvl_r;                  // filtered pin level
  logic [15:0]       ctrl_r;                 // control word
  logic [POS_W-1:0]  pos_r  [N_IN][2];       // captured positions
  logic [CNT_W-1:0]  cnt_r  [N_IN][2];       // event counters
  logic              flag_r [N_IN][2];       // value captured flags
  logic [N_IN-1:0]   lvl_nxt;                // next filtered level
  logic              edge_w [N_IN][2];       // qualified edge pulses
  logic              take_w [N_IN][2];       // capture happens this cycle
  logic [N_IN-1:0]   act_rise_w;             // input being activated
  logic              ctl_wr_w;               // control word written

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // field of one input in a 16-bit word
  // input 2 sits one byte above input 1, so one helper serves both
  function automatic logic fld(input logic [15:0] w, input int in_idx, input int pos);
    fld = w[in_idx*IN_STRIDE + pos];
  endfunction : fld

  // whether an edge is to be latched, given the input's control settings
  function automatic logic take_edge(input logic [15:0] ctl, input int in_idx,
                                     input int en_pos, input logic seen,
                                     input logic flagged);
    take_edge = seen && fld(ctl, in_idx, CTL_ACT) && fld(ctl, in_idx, en_pos)
                && (fld(ctl, in_idx, CTL_CONT) || !flagged);
  endfunction : take_edge

  // status word built from live state
  // built at read time, so it can never disagree with the flags
  function automatic logic [15:0] status_word(input logic [15:0] ctl,
                                              input logic f10, input logic f11,
                                              input logic f20, input logic f21);
    status_word = 16'h0000;
    status_word[ST_ACT]             = ctl[CTL_ACT];
    status_word[ST_RISE]            = f10;
    status_word[ST_FALL]            = f11;
    status_word[IN_STRIDE + ST_ACT]  = ctl[IN_STRIDE + CTL_ACT];
    status_word[IN_STRIDE + ST_RISE] = f20;
    status_word[IN_STRIDE + ST_FALL] = f21;
  endfunction : status_word

  // ----------------------------------------------------------------
  // pin synchroniser and edge filter
  // ----------------------------------------------------------------
  // three stages; a change is believed only once stages two and three agree,
  // which also rejects a single-cycle glitch that survives stage one
  // the cost is latency: a pin change shows up three to four cycles late,
  // and pulses narrower than two cycles are lost
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < N_IN; i++) begin
        sync_r[i] <= '0;
      end
      lvl_r <= '0;
    end else begin
      for (int i = 0; i < N_IN; i++) begin
        sync_r[i] <= {sync_r[i][SYNC_W-2:0], cap_pin_in[i]};
      end
      lvl_r <= lvl_nxt;
    end
  end

  // edges come from the agreed level against the held level
  always_comb begin
    for (int i = 0; i < N_IN; i++) begin
      lvl_nxt[i] = (sync_r[i][1] == sync_r[i][2]) ? sync_r[i][2] : lvl_r[i];
      edge_w[i][EDGE_RISE] = lvl_nxt[i] && !lvl_r[i];
      edge_w[i][EDGE_FALL] = !lvl_nxt[i] && lvl_r[i];
    end
  end

  // ----------------------------------------------------------------
  // control word
  // ----------------------------------------------------------------
  // only the control word takes writes; positions and counters have no
  // write path at all, so a stray write cannot disturb them
  assign ctl_wr_w = req_in.wr && (req_in.addr == ADR_CONTROL);

  // activation is the 0 to 1 step of the activate bit
  // writing one over one clears nothing; software must deactivate first
  always_comb begin
    for (int i = 0; i < N_IN; i++) begin
      act_rise_w[i] = ctl_wr_w && fld(req_in.wdata, i, CTL_ACT)
                      && !fld(ctrl_r, i, CTL_ACT);
    end
  end

  // reserved bits are dropped, so they always read back as zero
  // the new word takes effect from the next cycle on
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_r <= CTL_RESET;
    end else if (ctl_wr_w) begin
      ctrl_r <= req_in.wdata & CTL_MASK;
    end
  end

  // ----------------------------------------------------------------
  // capture decision
  // ----------------------------------------------------------------
  // uses the control word in force before this cycle's write
  // a one-time slot stays closed after its first capture until a fresh
  // activation clears its flag and re-arms it
  always_comb begin
    for (int i = 0; i < N_IN; i++) begin
      take_w[i][EDGE_RISE] = take_edge(ctrl_r, i, CTL_RISE, edge_w[i][EDGE_RISE],
                                       flag_r[i][EDGE_RISE]);
      take_w[i][EDGE_FALL] = take_edge(ctrl_r, i, CTL_FALL, edge_w[i][EDGE_FALL],
                                       flag_r[i][EDGE_FALL]);
    end
  end

  // ----------------------------------------------------------------
  // captured positions
  // ----------------------------------------------------------------
  // a fresh capture wins over an origin shift in the same cycle, since the
  // incoming position is already in the new reference
  // the shift is a plain wrapping add; slots never captured move too,
  // which is harmless because their flag still reads zero
  // the port has no write path into these registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < N_IN; i++) begin
        for (int e = 0; e < 2; e++) begin
          pos_r[i][e] <= '0;
        end
      end
    end else begin
      for (int i = 0; i < N_IN; i++) begin
        for (int e = 0; e < 2; e++) begin
          if (take_w[i][e]) begin
            pos_r[i][e] <= motor_pos_in;
          end else if (origin_in.shift) begin
            pos_r[i][e] <= pos_r[i][e] + origin_in.delta;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // event counters and captured flags
  // ----------------------------------------------------------------
  // activation clears; the input was inactive before, so no capture collides
  // counters roll over at full scale, so software must read them often
  // enough to take differences; deactivation keeps counts and flags
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < N_IN; i++) begin
        for (int e = 0; e < 2; e++) begin
          cnt_r[i][e]  <= '0;
          flag_r[i][e] <= 1'b0;
        end
      end
    end else begin
      for (int i = 0; i < N_IN; i++) begin
        for (int e = 0; e < 2; e++) begin
          if (act_rise_w[i]) begin
            cnt_r[i][e]  <= '0;
            flag_r[i][e] <= 1'b0;
          end else if (take_w[i][e]) begin
            cnt_r[i][e]  <= cnt_r[i][e] + 1'b1;
            flag_r[i][e] <= 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // writes to anything but the control word fall through untouched
  // the answer is registered: it appears one cycle after the strobe and
  // stands until the next read, while rd_valid_out marks that one cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out  <= '0;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= req_in.rd;
      if (req_in.rd) begin
        case (req_in.addr)
          ADR_IN1_RISE_POS: rd_data_out <= pos_r[0][EDGE_RISE];
          ADR_IN1_FALL_POS: rd_data_out <= pos_r[0][EDGE_FALL];
          ADR_IN2_RISE_POS: rd_data_out <= pos_r[1][EDGE_RISE];
          ADR_IN2_FALL_POS: rd_data_out <= pos_r[1][EDGE_FALL];
          ADR_IN1_RISE_CNT: rd_data_out <= {16'h0000, cnt_r[0][EDGE_RISE]};
          ADR_IN1_FALL_CNT: rd_data_out <= {16'h0000, cnt_r[0][EDGE_FALL]};
          ADR_IN2_RISE_CNT: rd_data_out <= {16'h0000, cnt_r[1][EDGE_RISE]};
          ADR_IN2_FALL_CNT: rd_data_out <= {16'h0000, cnt_r[1][EDGE_FALL]};
          ADR_SUMMARY: begin
            rd_data_out <= {16'h0000,
                            cnt_r[1][EDGE_FALL][NIB_W-1:0],
                            cnt_r[1][EDGE_RISE][NIB_W-1:0],
                            cnt_r[0][EDGE_FALL][NIB_W-1:0],
                            cnt_r[0][EDGE_RISE][NIB_W-1:0]};
          end
          ADR_CONTROL: rd_data_out <= {16'h0000, ctrl_r};
          ADR_STATUS: begin
            rd_data_out <= {16'h0000, status_word(ctrl_r, flag_r[0][0], flag_r[0][1],
                                                  flag_r[1][0], flag_r[1][1])};
          end
          default: rd_data_out <= '0;   // unmapped reads answer zero
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // every check runs on the drive clock and sleeps through reset
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_in1_rise_pos: assert property (take_w[0][EDGE_RISE] |=>
    pos_r[0][EDGE_RISE] == $past(motor_pos_in)) else $error("in1 rise not stored");
  a_in2_fall_pos: assert property (take_w[1][EDGE_FALL] |=>
    pos_r[1][EDGE_FALL] == $past(motor_pos_in)) else $error("in2 fall not stored");
  a_origin_shift: assert property (origin_in.shift && !take_w[0][EDGE_FALL] |=>
    pos_r[0][EDGE_FALL] == $past(pos_r[0][EDGE_FALL]) + $past(origin_in.delta))
    else $error("position not shifted");
  a_count_step: assert property (take_w[0][EDGE_RISE] && !act_rise_w[0] |=>
    cnt_r[0][EDGE_RISE] == $past(cnt_r[0][EDGE_RISE]) + 16'h0001)
    else $error("counter did not step");
  a_count_idle: assert property (!take_w[1][EDGE_RISE] && !act_rise_w[1] |=>
    $stable(cnt_r[1][EDGE_RISE])) else $error("counter moved without capture");
  a_count_clear: assert property (act_rise_w[0] |=>
    cnt_r[0][EDGE_RISE] == '0 && cnt_r[0][EDGE_FALL] == '0) else $error("no clear");

  a_oneshot_hold: assert property (flag_r[1][EDGE_RISE] && !fld(ctrl_r, 1, CTL_CONT)
    && !origin_in.shift |=> $stable(pos_r[1][EDGE_RISE])) else $error("one-time recaptured");

  a_summary_pack: assert property (req_in.rd && req_in.addr == ADR_SUMMARY |=>
    rd_data_out[7:4] == $past(cnt_r[0][EDGE_FALL][NIB_W-1:0]) && rd_valid_out)
    else $error("summary packing wrong");

  a_status_flag: assert property (take_w[1][EDGE_RISE] && !act_rise_w[1] |=>
    flag_r[1][EDGE_RISE]) else $error("status flag not set");

  a_ro_write: assert property (req_in.wr && req_in.addr == ADR_IN1_RISE_CNT
    && !take_w[0][EDGE_RISE] && !act_rise_w[0] |=> $stable(cnt_r[0][EDGE_RISE]))
    else $error("read-only counter written");

  // the other two slots latch, and a slot stands unless captured or shifted
  a_in1_fall_pos: assert property (take_w[0][EDGE_FALL] |=>
    pos_r[0][EDGE_FALL] == $past(motor_pos_in)) else $error("in1 fall not stored");
  a_in2_rise_pos: assert property (take_w[1][EDGE_RISE] |=>
    pos_r[1][EDGE_RISE] == $past(motor_pos_in)) else $error("in2 rise not stored");
  a_in1_rise_hold: assert property (!take_w[0][EDGE_RISE] && !origin_in.shift |=>
    $stable(pos_r[0][EDGE_RISE])) else $error("in1 rise position moved");

  // every counter steps by one per capture and rolls over at full scale
  a_in1_fall_count: assert property (take_w[0][EDGE_FALL] |=>
    cnt_r[0][EDGE_FALL] == $past(cnt_r[0][EDGE_FALL]) + 16'h0001)
    else $error("in1 fall counter did not step");
  a_in2_rise_count: assert property (take_w[1][EDGE_RISE] |=>
    cnt_r[1][EDGE_RISE] == $past(cnt_r[1][EDGE_RISE]) + 16'h0001)
    else $error("in2 rise counter did not step");
  a_in2_fall_count: assert property (take_w[1][EDGE_FALL] |=>
    cnt_r[1][EDGE_FALL] == $past(cnt_r[1][EDGE_FALL]) + 16'h0001)
    else $error("in2 fall counter did not step");
  a_in1_fall_idle: assert property (!take_w[0][EDGE_FALL] && !act_rise_w[0] |=>
    $stable(cnt_r[0][EDGE_FALL])) else $error("counter moved without capture");

  // activation clears both counters and both flags of that input
  a_in2_count_clear: assert property (act_rise_w[1] |=>
    cnt_r[1][EDGE_RISE] == '0 && cnt_r[1][EDGE_FALL] == '0) else $error("in2 no clear");
  a_in1_flag_clear: assert property (act_rise_w[0] |=>
    !flag_r[0][EDGE_RISE] && !flag_r[0][EDGE_FALL]) else $error("in1 flags not cleared");

  // an inactive input or a disabled edge leaves its counter alone
  a_inactive_hold: assert property (edge_w[0][EDGE_RISE] && !fld(ctrl_r, 0, CTL_ACT)
    && !act_rise_w[0] |=> $stable(cnt_r[0][EDGE_RISE])) else $error("inactive input counted");
  a_edge_disabled: assert property (edge_w[1][EDGE_FALL] && !fld(ctrl_r, 1, CTL_FALL)
    && !act_rise_w[1] |=> $stable(cnt_r[1][EDGE_FALL])) else $error("disabled edge counted");

  // the remaining nibbles of the summary word
  a_summary_low: assert property (req_in.rd && req_in.addr == ADR_SUMMARY |=>
    rd_data_out[3:0] == $past(cnt_r[0][EDGE_RISE][NIB_W-1:0]))
    else $error("summary low nibble wrong");
  a_summary_mid: assert property (req_in.rd && req_in.addr == ADR_SUMMARY |=>
    rd_data_out[11:8] == $past(cnt_r[1][EDGE_RISE][NIB_W-1:0]))
    else $error("summary input 2 rise nibble wrong");
  a_summary_high: assert property (req_in.rd && req_in.addr == ADR_SUMMARY |=>
    rd_data_out[15:12] == $past(cnt_r[1][EDGE_FALL][NIB_W-1:0]))
    else $error("summary input 2 fall nibble wrong");

  // main scenarios the bench is expected to reach
  c_in1_capture:  cover property (take_w[0][EDGE_RISE] ##[1:20] take_w[0][EDGE_FALL]);
  c_in2_capture:  cover property (take_w[1][EDGE_FALL]);
  c_origin_shift: cover property (flag_r[0][EDGE_RISE] && origin_in.shift);
  c_reactivate:   cover property (flag_r[1][EDGE_RISE] ##1 act_rise_w[1]);

endmodule : dipc_capture
`default_nettype wire

// ### dipc_far_model.sv
/*
  far side model: motor position source and the two capture pins.
  assumes the bench steers target levels; outputs move on clk_in rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
module dipc_far_model (
  input  wire logic                       clk_in,        // drive clock
  input  wire logic                       rst_in,        // async reset, high
  input  wire logic [dipc_pkg::N_IN-1:0]  pin_set_in,    // target pin levels
  input  wire logic [dipc_pkg::POS_W-1:0] pos_set_in,    // target motor position
  output logic      [dipc_pkg::N_IN-1:0]  cap_pin_out,   // capture pins to block
  output logic      [dipc_pkg::POS_W-1:0] motor_pos_out  // position to block
);
  import dipc_pkg::*;
  // ----------------------------------------------------------------
  // pin driver
  // ----------------------------------------------------------------
  // pins rest low like an input with pull-down; bench holds each level >= 8 cycles
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cap_pin_out <= '0;
    end else begin
      cap_pin_out <= pin_set_in;
    end
  end
  // ----------------------------------------------------------------
  // position source
  // ----------------------------------------------------------------
  // position moves with the pin and then stands, so the latched value is unambiguous
  always_ff @(posedge clk_in) begin
    motor_pos_out <= pos_set_in;
  end
endmodule : dipc_far_model
`default_nettype wire

// ### dipc_capture_tb_top.sv
/*
  self-checking bench for dipc_capture: reads go through a queue of expected words.
  assumes dipc_pkg and dipc_far_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module dipc_capture_tb_top;
  import dipc_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                  clk_in;           // 100 MHz
  logic                  rst_in;           // async reset
  logic [N_IN-1:0]       pin_set;          // requested pin levels
  logic [POS_W-1:0]      pos_set;          // requested motor position
  logic [N_IN-1:0]       cap_pin;          // pins as driven by the model
  logic [POS_W-1:0]      motor_pos;        // position as driven by the model
  dipc_origin_type       origin_r;         // origin shift pulse
  dipc_req_type          req_r;            // parameter access
  logic [DATA_W-1:0]     rd_data;          // read answer
  logic                  rd_valid;         // answer strobe
  logic [DATA_W-1:0]     exp_q[$];         // expected read words, oldest first
  logic [POS_W-1:0]      exp_pos[4];       // in1R in1F in2R in2F
  logic [CNT_W-1:0]      exp_cnt[4];       // same order
  logic [POS_W-1:0]      delta;            // origin shift amount
  int                    num_errors;
  int                    n_compared;

  dipc_capture uut (.clk_in(clk_in), .rst_in(rst_in), .cap_pin_in(cap_pin),
    .motor_pos_in(motor_pos), .origin_in(origin_r), .req_in(req_r),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid));
  dipc_far_model far (.clk_in(clk_in), .rst_in(rst_in), .pin_set_in(pin_set),
    .pos_set_in(pos_set), .cap_pin_out(cap_pin), .motor_pos_out(motor_pos));

  // ----------------------------------------------------------------
  // clock, monitor, watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // every answer strobe consumes the oldest note; a stray answer mismatches
  always @(posedge clk_in) begin
    if (rd_valid === 1'b1) begin
      chk(rd_data, (exp_q.size() != 0) ? exp_q.pop_front() : 32'hxxxx_xxxx);
    end
  end
  // the whole run needs about 600 cycles; this allows far more
  initial begin
    #200000;
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test();
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clk_in);
    req_r <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in);
    req_r.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    exp_q.push_back(e);
    @(posedge clk_in);
    req_r <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk_in);
    req_r.rd <= 1'b0;
  endtask : rd
  // move one pin with a fresh position; take says whether a capture is due
  task automatic capture(input int i, input logic lvl, input logic take);
    int k;
    logic [POS_W-1:0] p;
    k = 2 * i + (lvl ? 0 : 1);
    p = $urandom;
    @(posedge clk_in);
    pin_set[i] <= lvl;
    pos_set <= p;
    repeat (8) @(posedge clk_in);
    if (take) begin
      exp_pos[k] = p;
      exp_cnt[k]++;
    end
  endtask : capture
  task automatic check_all();
    for (int k = 0; k < 4; k++) begin
      rd(ADR_IN1_RISE_POS + 16'(2 * k), exp_pos[k]);
      rd(ADR_IN1_RISE_CNT + 16'(2 * k), {16'h0000, exp_cnt[k]});
    end
    rd(ADR_SUMMARY, {16'h0000, exp_cnt[3][3:0], exp_cnt[2][3:0],
                     exp_cnt[1][3:0], exp_cnt[0][3:0]});
  endtask : check_all
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(61720));
    rst_in = 1'b1;
    pin_set = '0;
    pos_set = '0;
    origin_r = '0;
    req_r = '0;
    num_errors = 0;
    n_compared = 0;
    for (int k = 0; k < 4; k++) begin
      exp_pos[k] = '0;
      exp_cnt[k] = '0;
    end
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    // reset values and an unmapped read
    check_all();
    rd(ADR_CONTROL, 32'h0000_0000);
    rd(ADR_STATUS, 32'h0000_0000);
    rd(16'h0a52, 32'h0000_0000);
    $display("test reset done");
    // both inputs continuous on both edges; 17 rounds on input 1 wraps the nibble
    wr(ADR_CONTROL, 16'hffff);
    rd(ADR_CONTROL, 32'h0000_3333);
    for (int n = 0; n < 17; n++) begin
      capture(0, 1'b1, 1'b1);
      capture(0, 1'b0, 1'b1);
    end
    for (int n = 0; n < 3; n++) begin
      capture(1, 1'b1, 1'b1);
      capture(1, 1'b0, 1'b1);
    end
    check_all();
    rd(ADR_STATUS, 32'h0000_0707);
    $display("test continuous done");
    // writes to read-only words, then an origin shift
    for (int k = 0; k < 4; k++) begin
      wr(ADR_IN1_RISE_POS + 16'(2 * k), 16'($urandom));
      wr(ADR_IN1_RISE_CNT + 16'(2 * k), 16'($urandom));
    end
    wr(ADR_SUMMARY, 16'($urandom));
    delta = $urandom;
    @(posedge clk_in);
    origin_r <= '{shift: 1'b1, delta: delta};
    @(posedge clk_in);
    origin_r.shift <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      exp_pos[k] = exp_pos[k] + delta;
    end
    check_all();
    $display("test read-only and origin done");
    // input 2 re-activated one-time, rising only
    wr(ADR_CONTROL, 16'h0033);
    wr(ADR_CONTROL, 16'h1133);
    exp_cnt[2] = '0;
    exp_cnt[3] = '0;
    rd(ADR_STATUS, 32'h0000_0107);
    capture(1, 1'b1, 1'b1);
    capture(1, 1'b0, 1'b0);
    capture(1, 1'b1, 1'b0);
    capture(1, 1'b0, 1'b0);
    check_all();
    rd(ADR_STATUS, 32'h0000_0307);
    $display("test one-time done");
    // input 1 inactive ignores edges, re-activation clears its counters
    wr(ADR_CONTROL, 16'h1132);
    capture(0, 1'b1, 1'b0);
    capture(0, 1'b0, 1'b0);
    check_all();
    wr(ADR_CONTROL, 16'h1133);
    exp_cnt[0] = '0;
    exp_cnt[1] = '0;
    check_all();
    rd(ADR_STATUS, 32'h0000_0301);
    repeat (4) @(posedge clk_in);
    if (exp_q.size() != 0) begin
      num_errors++;
      $display("[ERR] %0t answers missing", $time);
    end
    $display("test activation done");
    end_of_test();
  end
endmodule : dipc_capture_tb_top
`default_nettype wire
